// File: fdsc_defines.svh
`ifndef FDSC_DEFINES_SVH
`define FDSC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FDSC_OFF_PIN_STATUS_B   3'h1
`define FDSC_OFF_DRIVE_CTL      3'h2
`define FDSC_OFF_TAPE_ASSIGN    3'h3

// ----------------------------------------
// Drive output control fields
// ----------------------------------------
`define FDSC_DOC_SEL_LO         1
`define FDSC_DOC_SEL_HI         0
`define FDSC_DOC_RESET_N        2
`define FDSC_DOC_DMA_EN         3
`define FDSC_DOC_MOTOR_LO       4
`define FDSC_DOC_RESET_VAL      8'h00

// ----------------------------------------
// Pin status B and tape fields
// ----------------------------------------
`define FDSC_PSB_WRITE_GATE_OUT          2
`define FDSC_PSB_RDATA          3
`define FDSC_PSB_WDATA          4
`define FDSC_PSB_GEN2_ONES      2'h3
`define FDSC_TAPE_NORMAL_OE     8'h03
`define FDSC_TAPE_NONE          2'h0

// ----------------------------------------
// Synchroniser vector layout
// ----------------------------------------
`define FDSC_SY_W               17
`define FDSC_SY_DIN_HI          7
`define FDSC_SY_ADDR_LO         8
`define FDSC_SY_IOW             11
`define FDSC_SY_IOR             12
`define FDSC_SY_CS              13
`define FDSC_SY_RDATA           14
`define FDSC_SY_DACK            15
`define FDSC_SY_TC              16

// ----------------------------------------
// Timing
// ----------------------------------------
`define FDSC_CLK_PERIOD_NS      20
`define FDSC_SWRST_MIN_NS       100
`define FDSC_SWRST_CYCLES       ((`FDSC_SWRST_MIN_NS + `FDSC_CLK_PERIOD_NS - 1) / `FDSC_CLK_PERIOD_NS)

`endif

// File: fdsc_host_model.sv
`timescale 1ns/100ps
module fdsc_host_model (
    // Bus pins
    input  wire logic       mclk,
    output logic            host_cs_n,
    output logic            host_ior_n,
    output logic            host_iow_n,
    output logic      [2:0] host_addr,
    output logic      [7:0] host_din,
    input  wire logic [7:0] host_dout,
    input  wire logic [7:0] host_doe
);
    // ----------------------------------------
    // Byte-wide I/O cycles
    // ----------------------------------------
    initial begin
        host_cs_n = 1'b1;
        host_ior_n = 1'b1;
        host_iow_n = 1'b1;
        host_addr = 3'h0;
        host_din = 8'h00;
    end

    // Strobes held six cycles, address held four more, then three idle
    task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic [7:0] e);
        @(negedge mclk);
        host_cs_n = 1'b0;
        host_addr = a;
        host_din = d;
        host_iow_n = !wr;
        host_ior_n = wr;
        repeat (6) @(negedge mclk);
        q = host_dout;
        e = host_doe;
        host_ior_n = 1'b1;
        host_iow_n = 1'b1;
        repeat (4) @(negedge mclk);
        // Released lines flip so stale values never read as valid
        host_cs_n = 1'b1;
        host_addr = ~a;
        host_din = ~d;
        repeat (3) @(negedge mclk);
    endtask
endmodule

// File: fdsc_pkg.sv
package fdsc_pkg;

    // ----------------------------------------
    // Interface modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        FDSC_MODE_AT,
        FDSC_MODE_GEN2,
        FDSC_MODE_COMPACT
    } fdsc_mode_t;

    // ----------------------------------------
    // Whole register state of the block
    // ----------------------------------------
    typedef struct packed {
        logic [16:0] sync_a;
        logic [16:0] sync_b;
        logic        ior_d;
        logic        iow_d;
        logic        rdata_n_d;
        logic        wdata_n_d;
        logic        write_gate_out_d;
        logic [7:0]  drive_ctl;
        logic [1:0]  tape_sel;
        logic [2:0]  swrst_cnt;
        logic        tog_rd;
        logic        tog_wr;
        logic        lat_wg;
        logic        lat_rd;
        logic        lat_wr;
        logic [7:0]  dout;
        logic [7:0]  doe;
        logic [3:0]  drive_sel_n;
        logic [3:0]  motor_n;
        logic        soft_reset_n;
        logic        drq;
        logic        drq_oe;
        logic        irq;
        logic        irq_oe;
        logic        dack_n;
        logic        tc;
        logic [1:0]  tape_drive;
        logic        tape_hit;
    } fdsc_state_t;

endpackage

// File: fdsc_regs.sv
`timescale 1ns/100ps
`include "fdsc_defines.svh"

// Overview of operation
// - Mode bits pick AT, second-generation or compact.
// - Enhanced-layout bit selects tape register layout.
// - Pin status B read-only; AT read floats.
// - Gen2: motors, write gate, select bit, ones.
// - Gen2 motor/select bits survive software reset.
// - Gen2 bits 3/4 toggle on data edges.
// - Compact: active-low drive selects, bit 7 one.
// - Compact bit 2 latches write gate rise.
// - Compact bits 3/4 latch data, input-read clears.
// - Drive control readable, writable, hardware reset only.
// - Bits 0-1 encode the selected drive.
// - Bit 2 low holds controller reset.
// - Software reset stretched to at least 100ns.
// - AT/compact: bit 3 gates DMA, interrupt pins.
// - Gen2: DMA and interrupt pins always enabled.
// - Bits 4-7 drive the four motor outputs.
// - Internal drives select only with motor bit.
// - Tape register holds two-bit tape drive number.
// - Tape handling applies to addressed tape drive.
// - Tape register survives software reset, follows layout.
// - Normal layout: bits 2-7 float on read.
module fdsc_regs #(
    parameter int INTERNAL_DRIVES = 2
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Host I/O bus pins
    input  wire logic       host_cs_n,
    input  wire logic       host_ior_n,
    input  wire logic       host_iow_n,
    input  wire logic [2:0] host_addr,
    input  wire logic [7:0] host_din,
    output logic      [7:0] host_dout,
    output logic      [7:0] host_doe,
    // Configuration
    input  wire logic       mode_sel,
    input  wire logic       encoding_sel,
    input  wire logic       enhanced_layout,
    // Controller core
    input  wire logic       write_gate_out,
    input  wire logic       write_data_n,
    input  wire logic       dir_read,
    input  wire logic       core_drq,
    input  wire logic       core_irq,
    input  wire logic [1:0] op_drive,
    // Drive interface pins
    input  wire logic       read_data_n,
    output logic      [3:0] drive_sel_n,
    output logic      [3:0] motor_out_n,
    // DMA and interrupt pins
    input  wire logic       dma_ack_n,
    input  wire logic       term_count,
    output logic            dma_req,
    output logic            dma_req_oe,
    output logic            controller_irq,
    output logic            controller_irq_oe,
    output logic            dma_ack_gated_n,
    output logic            term_count_gated,
    // Controller reset and tape support
    output logic            soft_reset_n,
    output logic      [1:0] tape_drive,
    output logic            tape_op
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam logic [2:0] SWRST_CYC = 3'(`FDSC_SWRST_CYCLES);

    fdsc_pkg::fdsc_state_t      st;
    fdsc_pkg::fdsc_state_t      next_st;
    fdsc_pkg::fdsc_mode_t       mode;
    logic [`FDSC_SY_W-1:0]      pins_raw;

    assign pins_raw = {term_count, dma_ack_n, read_data_n, host_cs_n,
                       host_ior_n, host_iow_n, host_addr, host_din};

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    always_comb begin
        if (!mode_sel && encoding_sel) begin
            mode = fdsc_pkg::FDSC_MODE_GEN2;
        end else if (!mode_sel && !encoding_sel) begin
            mode = fdsc_pkg::FDSC_MODE_COMPACT;
        end else begin
            mode = fdsc_pkg::FDSC_MODE_AT;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [`FDSC_SY_W-1:0] sy;
        logic [2:0]            addr;
        logic [7:0]            din;
        logic                  sel;
        logic                  wr_done;
        logic                  rd_act;
        logic                  rd_rise;
        logic                  wd_rise;
        logic                  wg_rise;
        logic                  pins_on;
        logic [7:0]            doc;
        logic [7:0]            stat_b;
        logic [1:0]            dsel;
        sy      = '0;
        addr    = '0;
        din     = '0;
        sel     = 1'b0;
        wr_done = 1'b0;
        rd_act  = 1'b0;
        rd_rise = 1'b0;
        wd_rise = 1'b0;
        wg_rise = 1'b0;
        pins_on = 1'b0;
        doc     = '0;
        stat_b  = '0;
        dsel    = '0;
        next_st = st;

        // Two-flop synchronisers; only stage two is looked at
        next_st.sync_a = pins_raw;
        next_st.sync_b = st.sync_a;
        sy             = st.sync_b;
        addr           = sy[`FDSC_SY_ADDR_LO +: 3];
        din            = sy[`FDSC_SY_DIN_HI:0];
        sel            = !sy[`FDSC_SY_CS];
        next_st.ior_d  = sy[`FDSC_SY_IOR];
        next_st.iow_d  = sy[`FDSC_SY_IOW];
        // Write taken at strobe release, when data is surely settled
        wr_done        = sel && sy[`FDSC_SY_IOW] && !st.iow_d;
        rd_act         = sel && !sy[`FDSC_SY_IOR];

        // Inactive edges of active-low data, active edge of gate
        next_st.rdata_n_d = sy[`FDSC_SY_RDATA];
        next_st.wdata_n_d = write_data_n;
        next_st.write_gate_out_d   = write_gate_out;
        rd_rise           = sy[`FDSC_SY_RDATA] && !st.rdata_n_d;
        wd_rise           = write_data_n && !st.wdata_n_d;
        wg_rise           = write_gate_out && !st.write_gate_out_d;

        // ------------------------------------
        // Register writes
        // ------------------------------------
        doc = st.drive_ctl;
        if (wr_done && addr == `FDSC_OFF_DRIVE_CTL) begin
            doc = din;
        end
        if (wr_done && addr == `FDSC_OFF_TAPE_ASSIGN) begin
            next_st.tape_sel = din[1:0];
        end
        next_st.drive_ctl = doc;

        // Software reset, stretched so a quick toggle still counts
        if (!doc[`FDSC_DOC_RESET_N]) begin
            next_st.swrst_cnt = SWRST_CYC;
        end else if (st.swrst_cnt != 3'h0) begin
            next_st.swrst_cnt = st.swrst_cnt - 3'h1;
        end
        next_st.soft_reset_n = doc[`FDSC_DOC_RESET_N] && (st.swrst_cnt == 3'h0);

        // ------------------------------------
        // Drive selects and motors
        // ------------------------------------
        dsel = doc[`FDSC_DOC_SEL_LO:`FDSC_DOC_SEL_HI];
        for (int i = 0; i < 4; i++) begin
            next_st.motor_n[i] = !doc[`FDSC_DOC_MOTOR_LO + i];
            if (i < INTERNAL_DRIVES) begin
                next_st.drive_sel_n[i] = !(dsel == 2'(i) && doc[`FDSC_DOC_MOTOR_LO + i]);
            end else begin
                next_st.drive_sel_n[i] = !(dsel == 2'(i));
            end
        end

        // ------------------------------------
        // Data toggles and latches
        // ------------------------------------
        if (rd_rise) begin
            next_st.tog_rd = !st.tog_rd;
        end
        if (wd_rise) begin
            next_st.tog_wr = !st.tog_wr;
        end
        // Set beats a same-cycle clear by the input register read
        if (wg_rise) begin
            next_st.lat_wg = 1'b1;
        end else if (dir_read) begin
            next_st.lat_wg = 1'b0;
        end
        if (rd_rise) begin
            next_st.lat_rd = 1'b1;
        end else if (dir_read) begin
            next_st.lat_rd = 1'b0;
        end
        // Not qualified by the write gate
        if (wd_rise) begin
            next_st.lat_wr = 1'b1;
        end else if (dir_read) begin
            next_st.lat_wr = 1'b0;
        end

        // ------------------------------------
        // Pin status B view
        // ------------------------------------
        if (mode == fdsc_pkg::FDSC_MODE_COMPACT) begin
            stat_b = {1'b1, st.drive_sel_n[1], st.drive_sel_n[0], st.lat_wr,
                      st.lat_rd, st.lat_wg, st.drive_sel_n[3], st.drive_sel_n[2]};
        end else begin
            stat_b = {`FDSC_PSB_GEN2_ONES, st.drive_ctl[`FDSC_DOC_SEL_HI], st.tog_wr,
                      st.tog_rd, write_gate_out,
                      st.drive_ctl[`FDSC_DOC_MOTOR_LO + 1],
                      st.drive_ctl[`FDSC_DOC_MOTOR_LO]};
        end

        // ------------------------------------
        // Read data and lane enables
        // ------------------------------------
        next_st.dout = 8'h00;
        next_st.doe  = 8'h00;
        if (rd_act) begin
            unique case (addr)
                `FDSC_OFF_PIN_STATUS_B: begin
                    next_st.dout = stat_b;
                    next_st.doe  = (mode == fdsc_pkg::FDSC_MODE_AT) ? 8'h00 : 8'hFF;
                end
                `FDSC_OFF_DRIVE_CTL: begin
                    next_st.dout = st.drive_ctl;
                    next_st.doe  = 8'hFF;
                end
                `FDSC_OFF_TAPE_ASSIGN: begin
                    next_st.dout = {6'h00, st.tape_sel};
                    // Enhanced extras live outside this block; upper bits read zero
                    next_st.doe  = enhanced_layout ? 8'hFF : `FDSC_TAPE_NORMAL_OE;
                end
                default: begin
                    next_st.dout = 8'h00;
                    next_st.doe  = 8'h00;
                end
            endcase
        end

        // ------------------------------------
        // DMA and interrupt pin gating
        // ------------------------------------
        pins_on = (mode == fdsc_pkg::FDSC_MODE_GEN2) || doc[`FDSC_DOC_DMA_EN];
        next_st.drq     = core_drq;
        next_st.drq_oe  = pins_on;
        next_st.irq     = core_irq;
        next_st.irq_oe  = pins_on;
        next_st.dack_n  = sy[`FDSC_SY_DACK] || !pins_on;
        next_st.tc      = sy[`FDSC_SY_TC] && pins_on;

        // ------------------------------------
        // Tape support
        // ------------------------------------
        next_st.tape_drive = st.tape_sel;
        // Drive 0 never matches since code 00 means none
        next_st.tape_hit = (st.tape_sel != `FDSC_TAPE_NONE) && (op_drive == st.tape_sel);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st              <= '0;
            st.sync_a       <= '1;
            st.sync_b       <= '1;
            st.ior_d        <= 1'b1;
            st.iow_d        <= 1'b1;
            st.rdata_n_d    <= 1'b1;
            st.wdata_n_d    <= 1'b1;
            st.drive_ctl    <= `FDSC_DOC_RESET_VAL;
            st.drive_sel_n  <= 4'hF;
            st.motor_n      <= 4'hF;
            st.dack_n       <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign host_dout         = st.dout;
    assign host_doe          = st.doe;
    assign drive_sel_n       = st.drive_sel_n;
    assign motor_out_n       = st.motor_n;
    assign dma_req           = st.drq;
    assign dma_req_oe        = st.drq_oe;
    assign controller_irq    = st.irq;
    assign controller_irq_oe = st.irq_oe;
    assign dma_ack_gated_n   = st.dack_n;
    assign term_count_gated  = st.tc;
    assign soft_reset_n      = st.soft_reset_n;
    assign tape_drive        = st.tape_drive;
    assign tape_op           = st.tape_hit;

endmodule

// File: fdsc_regs_chk_properties.sv
`timescale 1ns/100ps
module fdsc_regs_chk #(
    parameter int INTERNAL_DRIVES = 2
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Watched ports
    input wire logic       host_ior_n,
    input wire logic [7:0] host_doe,
    input wire logic       mode_sel,
    input wire logic       encoding_sel,
    input wire logic [1:0] op_drive,
    input wire logic [3:0] drive_sel_n,
    input wire logic [3:0] motor_out_n,
    input wire logic       dma_req_oe,
    input wire logic       controller_irq_oe,
    input wire logic       dma_ack_gated_n,
    input wire logic       term_count_gated,
    input wire logic       soft_reset_n,
    input wire logic [1:0] tape_drive,
    input wire logic       tape_op
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic gen2;
    assign gen2 = !mode_sel && encoding_sel;

    sel_onehot_a: assert property ($onehot0(~drive_sel_n))
        else $error("More than one drive select low");
    int_drive_a: assert property (INTERNAL_DRIVES != 2 ||
        ((drive_sel_n[0] || !motor_out_n[0]) && (drive_sel_n[1] || !motor_out_n[1])))
        else $error("Internal drive selected without its motor");
    gen2_pins_a: assert property ($past(rst_n) && gen2 && $past(gen2) |-> dma_req_oe && controller_irq_oe)
        else $error("Pins disabled in second-generation mode");
    oe_pair_a: assert property ($past(rst_n) && !gen2 && !$past(gen2) |-> dma_req_oe == controller_irq_oe)
        else $error("Request and interrupt enables differ");
    gated_in_a: assert property ($past(!gen2 && !dma_req_oe) && !dma_req_oe |->
        dma_ack_gated_n && !term_count_gated)
        else $error("Acknowledge or count passed while disabled");
    read_drive_a: assert property (host_doe != 8'h00 |->
        !($past(host_ior_n, 2) && $past(host_ior_n, 3) && $past(host_ior_n, 4) && $past(host_ior_n, 5)))
        else $error("Data lines driven outside a read");
    swrst_width_a: assert property ($fell(soft_reset_n) |-> !soft_reset_n[*5])
        else $error("Controller reset shorter than five cycles");
    tape_hit_a: assert property ($past(rst_n) |->
        tape_op == ($past(op_drive) == tape_drive && tape_drive != 2'h0))
        else $error("Tape handling flag wrong");
endmodule

bind fdsc_regs fdsc_regs_chk #(.INTERNAL_DRIVES(INTERNAL_DRIVES)) fdsc_regs_chk_inst (
    .mclk, .rst_n, .host_ior_n, .host_doe, .mode_sel, .encoding_sel, .op_drive, .drive_sel_n,
    .motor_out_n, .dma_req_oe, .controller_irq_oe, .dma_ack_gated_n, .term_count_gated,
    .soft_reset_n, .tape_drive, .tape_op
);

// File: fdsc_regs_tb_top.sv
`timescale 1ns/100ps
module fdsc_regs_tb_top;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       host_cs_n, host_ior_n, host_iow_n;
    logic [2:0] host_addr;
    logic [7:0] host_din, host_dout, host_doe, q, e;
    logic       mode_sel, encoding_sel, enhanced_layout, write_gate_out, write_data_n;
    logic       dir_read, core_drq, core_irq, read_data_n, dma_ack_n, term_count;
    logic [1:0] op_drive, tape_drive;
    logic [3:0] drive_sel_n, motor_out_n;
    logic       dma_req, dma_req_oe, controller_irq, controller_irq_oe;
    logic       dma_ack_gated_n, term_count_gated, soft_reset_n, tape_op;
    int         failures = 0;
    int         cmp_count = 0;
    // Rows: written control byte, drive selects, motors
    logic [15:0] rows [8] = '{16'h1CEE, 16'h2DDD, 16'h4EBB, 16'h8F77,
                              16'h0CFF, 16'h1DFE, 16'h037F, 16'h06BF};

    always #10 mclk = ~mclk;

    fdsc_regs #(.INTERNAL_DRIVES(2)) fdsc_regs_inst (
        .mclk, .rst_n, .host_cs_n, .host_ior_n, .host_iow_n, .host_addr, .host_din,
        .host_dout, .host_doe, .mode_sel, .encoding_sel, .enhanced_layout, .write_gate_out,
        .write_data_n, .dir_read, .core_drq, .core_irq, .op_drive, .read_data_n,
        .drive_sel_n, .motor_out_n, .dma_ack_n, .term_count, .dma_req, .dma_req_oe,
        .controller_irq, .controller_irq_oe, .dma_ack_gated_n, .term_count_gated,
        .soft_reset_n, .tape_drive, .tape_op
    );
    fdsc_host_model fdsc_host_model_inst (
        .mclk, .host_cs_n, .host_ior_n, .host_iow_n, .host_addr, .host_din,
        .host_dout, .host_doe
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        cmp_count++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        fdsc_host_model_inst.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [2:0] a);
        fdsc_host_model_inst.xfer(1'b0, a, 8'h00, q, e);
    endtask

    task automatic hw_reset();
        rst_n = 1'b0;
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
    endtask

    task automatic data_pulse();
        read_data_n = 1'b0;
        write_data_n = 1'b0;
        repeat (5) @(negedge mclk);
        read_data_n = 1'b1;
        write_data_n = 1'b1;
        repeat (5) @(negedge mclk);
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge mclk);
        failures++;
        end_of_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        mode_sel = 1'b1;
        encoding_sel = 1'b1;
        enhanced_layout = 1'b0;
        write_gate_out = 1'b0;
        write_data_n = 1'b1;
        dir_read = 1'b0;
        core_drq = 1'b1;
        core_irq = 1'b1;
        op_drive = 2'h0;
        read_data_n = 1'b1;
        dma_ack_n = 1'b0;
        term_count = 1'b1;
        hw_reset();
        chk("motors", 8'h0F, {4'h0, motor_out_n});
        chk("selects", 8'h0F, {4'h0, drive_sel_n});
        rd(3'h2);
        chk("ctl reset", 8'h00, q);
        foreach (rows[i]) begin
            wr(3'h2, rows[i][15:8]);
            repeat (6) @(negedge mclk);
            chk("selects", {4'h0, rows[i][7:4]}, {4'h0, drive_sel_n});
            chk("motors", {4'h0, rows[i][3:0]}, {4'h0, motor_out_n});
            chk("ctl reset bit", {7'h0, rows[i][10]}, {7'h0, soft_reset_n});
            rd(3'h2);
            chk("ctl read", rows[i][15:8], q);
        end
        rd(3'h1);
        chk("status oe AT", 8'h00, e);
        rd(3'h0);
        chk("unmapped oe", 8'h00, e);
        wr(3'h3, 8'hFF);
        rd(3'h3);
        chk("tape oe", 8'h03, e);
        chk("tape sel", 8'h03, {6'h0, q[1:0]});
        chk("tape drive", 8'h03, {6'h0, tape_drive});
        enhanced_layout = 1'b1;
        rd(3'h3);
        chk("tape enh", 8'h03, q);
        chk("tape enh oe", 8'hFF, e);
        enhanced_layout = 1'b0;
        chk("pins off", 8'h02, {4'h0, dma_req_oe, controller_irq_oe, dma_ack_gated_n, term_count_gated});
        wr(3'h2, 8'h0E);
        chk("pins on", 8'h0D, {4'h0, dma_req_oe, controller_irq_oe, dma_ack_gated_n, term_count_gated});
        core_drq = 1'b0;
        repeat (2) @(negedge mclk);
        chk("req irq", 8'h01, {6'h0, dma_req, controller_irq});
        core_drq = 1'b1;
        wr(3'h2, 8'h0A);
        chk("ctl reset low", 8'h00, {7'h0, soft_reset_n});
        wr(3'h2, 8'h0E);
        chk("ctl reset held", 8'h00, {7'h0, soft_reset_n});
        repeat (6) @(negedge mclk);
        chk("ctl reset high", 8'h01, {7'h0, soft_reset_n});
        rd(3'h2);
        chk("ctl kept", 8'h0E, q);
        rd(3'h3);
        chk("tape kept", 8'h03, e & q);
        op_drive = 2'h3;
        repeat (3) @(negedge mclk);
        chk("tape op", 8'h01, {7'h0, tape_op});
        wr(3'h3, 8'h00);
        op_drive = 2'h0;
        repeat (3) @(negedge mclk);
        chk("tape op drive0", 8'h00, {7'h0, tape_op});
        hw_reset();
        rd(3'h2);
        chk("ctl hw reset", 8'h00, q);
        mode_sel = 1'b0;
        wr(3'h2, 8'h35);
        write_gate_out = 1'b1;
        rd(3'h1);
        chk("gen2 status", 8'hE7, q);
        data_pulse();
        rd(3'h1);
        chk("gen2 toggles", 8'hFF, q);
        wr(3'h2, 8'h31);
        rd(3'h1);
        chk("gen2 soft", 8'hFF, q);
        chk("gen2 pins", 8'h03, {6'h0, dma_req_oe, controller_irq_oe});
        write_gate_out = 1'b0;
        hw_reset();
        chk("gen2 pins reset", 8'h03, {6'h0, dma_req_oe, controller_irq_oe});
        encoding_sel = 1'b0;
        wr(3'h2, 8'h06);
        dir_read = 1'b1;
        @(negedge mclk);
        dir_read = 1'b0;
        rd(3'h1);
        chk("compact status", 8'hE2, q);
        data_pulse();
        rd(3'h1);
        chk("compact data", 8'hFA, q);
        write_gate_out = 1'b1;
        rd(3'h1);
        chk("compact gate", 8'hFE, q);
        write_gate_out = 1'b0;
        dir_read = 1'b1;
        @(negedge mclk);
        dir_read = 1'b0;
        rd(3'h1);
        chk("compact clear", 8'hE2, q);
        end_of_test();
    end
endmodule
